// File: hw/em3_pkg.sv
package em3_pkg;
	// ========================================
	// bus layout
	localparam int PADDR_W = 8;
	localparam int PDATA_W = 32;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TXDATA = 8'h08;
	localparam logic [7:0] REG_RXDATA = 8'h0C;
	localparam logic [7:0] REG_CLRTX = 8'h10;
	localparam logic [7:0] REG_FILTER = 8'h14;
	localparam logic [7:0] REG_STATION = 8'h18;
	localparam int CTRL_RXEN = 0;
	localparam int ST_TXIRQ = 0;
	localparam int ST_TIMEOUT = 1;
	localparam int ST_RXNE = 2;
	localparam int ST_BUSY = 3;
	localparam int FLT_VAL = 8;
	// ========================================
	// receive control word
	localparam int CW_PHS = 11;
	localparam int CW_CRC = 12;
	localparam int CW_COLL = 13;
	localparam int CW_OVF = 14;
	localparam int CW_QEMPTY = 15;
	localparam logic [15:0] QEMPTY_WORD = 16'h8000;
	// ========================================
	// timing, from a 40 ns clock
	localparam int CLK_PERIOD_NS = 40;
	localparam int BIT_NS = 333;
	localparam int HALF_CYC = (BIT_NS / 2) / CLK_PERIOD_NS;
	localparam int RX_MID_MIN = HALF_CYC * 3 / 2;
	localparam int RX_PHASE_MAX = HALF_CYC / 2;
	localparam int RX_END_IDLE = HALF_CYC * 3;
	localparam int SLOT_US = 42;
	localparam int SLOT_CYC = SLOT_US * 1000 / CLK_PERIOD_NS;
	localparam int TIMEOUT_MS = 160;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int FRAG_BITS = 17;
	localparam int JAM_BITS = 32;
	localparam int MAX_BACKOFF = 8;
	// ========================================
	// storage and codes
	localparam int TXQ_DEPTH = 1024;
	localparam int RXQ_DEPTH = 2048;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;
	typedef enum logic [2:0] {TX_IDLE, TX_LOAD, TX_DEFER, TX_SEND, TX_JAM, TX_BACKOFF,
		TX_DONE} em3_tx_st_t;
	typedef enum logic [1:0] {SEG_START, SEG_DATA, SEG_CRC} em3_seg_t;
endpackage : em3_pkg

// File: hw/em3_crc16.sv
module em3_crc16 (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic en,
	input wire logic din,
	output logic [15:0] crc
);
	import em3_pkg::*;
	typedef struct packed {
		logic [15:0] r;
	} em3_crc_t;
	em3_crc_t s;
	em3_crc_t n;
	// ========================================
	// msb-first, no reflection, no final xor: running the received crc through
	// leaves zero, so the receiver needs no separate compare
	always_comb begin
		n = s;
		if (clr) begin
			n.r = CRC_INIT;
		end else if (en) begin
			n.r = {s.r[14:0], 1'b0} ^ ((s.r[15] ^ din) ? CRC_POLY : 16'h0000);
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
	assign crc = s.r;
endmodule : em3_crc16

// File: hw/em3_mac.sv
// Summary of operation
// - frame is start bit, destination byte, source byte, data words, 16-bit crc
// - destination zero is broadcast and accepted whatever the filter holds, if the receive queue has room
// - one transmit packet buffered; loaded fully before sending starts
// - transmit interrupt set when packet sent or aborted
// - receive interrupt high while the receive queue holds a packet
// - send start bit, shift words out, append computed crc
// - outgoing serial stream is manchester coded
// - defer transmission while carrier is present
// - collision during transmit aborts packet and sends jam
// - random backoff, uniform over 0 to min(retries,8) slots of 42 us
// - unlimited retries; give up after 160 ms and report timeout
// - receive stream decoded by digital pll into words
// - strip start bit, filter on destination address
// - 256-bit filter memory: one accepts, zero rejects
// - switch station address readable as a register
// - accepted packet queued with its status
// - check crc, whole words, phase distortion and collision
// - fragments under 17 bit times are dropped entirely
// - accepted packet colliding later is queued with error status
// - queued packet preceded by word count and status flags
// - timeout sets a status flag saying packet not sent
// - receive interrupt clears itself when queue empties
module em3_mac #(
	parameter int TIMEOUT_LIM = em3_pkg::TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [em3_pkg::PADDR_W-1:0] paddr,
	input wire logic [em3_pkg::PDATA_W-1:0] pwdata,
	output logic [em3_pkg::PDATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic tx_out,
	output logic tx_en,
	input wire logic rx_in,
	input wire logic carrier_in,
	input wire logic coll_in,
	input wire logic [7:0] station_sw,
	output logic tx_irq,
	output logic rx_irq
);
	import em3_pkg::*;
	typedef struct packed {
		logic car1, car2, col1, col2, rx1, rx2, rxp;
		logic [7:0] sw1, sw2;
		logic pready;
		logic [31:0] prdata;
		logic pslverr, rpop;
		logic rx_en;
		em3_tx_st_t st;
		em3_seg_t seg;
		logic [10:0] tx_cnt;
		logic [9:0] tx_ptr;
		logic [3:0] tx_bit;
		logic half;
		logic [1:0] div;
		logic [4:0] jam;
		logic [3:0] retries;
		logic [13:0] bo;
		logic [22:0] to;
		logic timeout, tx_irq, tx_out, tx_en;
		logic [15:0] lfsr;
		logic ract;
		logic [3:0] rcnt;
		logic [15:0] nbits;
		logic [15:0] rsh;
		logic [3:0] rbc;
		logic [15:0] pend;
		logic havep, first, acc, rcoll, rovf, rphs;
		logic [11:0] base, wp, wr_ptr, rd_ptr;
		logic [10:0] wc;
		logic rx_irq;
		logic [255:0] filt;
	} em3_state_t;

	// ========================================
	// reset release
	logic rs1;
	logic rst_n;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rs1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rs1 <= 1'b1;
			rst_n <= rs1;
		end
	end

	// ========================================
	// packet storage, kept apart from the state struct so it is not copied
	em3_state_t s;
	em3_state_t n;
	logic [15:0] txm [TXQ_DEPTH];
	logic [15:0] rxq [RXQ_DEPTH];
	logic txm_we;
	logic rxq_we;
	logic [10:0] rxq_wa;
	logic [15:0] rxq_wd;
	always_ff @(posedge clk) begin
		if (txm_we) begin
			txm[s.tx_ptr] <= pwdata[15:0];
		end
		if (rxq_we) begin
			rxq[rxq_wa] <= rxq_wd;
		end
	end

	// ========================================
	// crc units, one polynomial and seed for both directions
	logic tcrc_clr, tcrc_en, tcrc_din;
	logic rcrc_clr, rcrc_en, rcrc_din;
	logic [15:0] tcrc;
	logic [15:0] rcrc;
	em3_crc16 u_tx_crc (
		.clk(clk),
		.rst_n(rst_n),
		.clr(tcrc_clr),
		.en(tcrc_en),
		.din(tcrc_din),
		.crc(tcrc)
	);
	em3_crc16 u_rx_crc (
		.clk(clk),
		.rst_n(rst_n),
		.clr(rcrc_clr),
		.en(rcrc_en),
		.din(rcrc_din),
		.crc(rcrc)
	);

	// ========================================
	// next state
	logic hb, wr_done, rd_done, acc_ph, rx_ne, timed_out, cur_bit, e, rx_end, bitv;
	logic [15:0] w;
	logic [31:0] rdv;
	logic [3:0] rnew;
	logic [3:0] slots;
	always_comb begin
		n = s;
		txm_we = 1'b0;
		rxq_we = 1'b0;
		rxq_wa = '0;
		rxq_wd = '0;
		tcrc_clr = 1'b0;
		tcrc_en = 1'b0;
		tcrc_din = 1'b0;
		rcrc_clr = 1'b0;
		rcrc_en = 1'b0;
		rcrc_din = 1'b0;
		w = '0;
		rdv = '0;
		rnew = '0;
		slots = '0;
		bitv = 1'b0;
		// pin synchronisers
		n.car1 = carrier_in;
		n.car2 = s.car1;
		n.col1 = coll_in;
		n.col2 = s.col1;
		n.rx1 = rx_in;
		n.rx2 = s.rx1;
		n.rxp = s.rx2;
		n.sw1 = station_sw;
		n.sw2 = s.sw1;
		// always stepping, even when idle, so stations decorrelate
		n.lfsr = {s.lfsr[14:0], ^(s.lfsr & LFSR_TAPS)};
		hb = (s.div == 2'(HALF_CYC - 1));
		n.div = hb ? 2'h0 : s.div + 2'h1;
		rx_ne = (s.wr_ptr != s.rd_ptr);

		// ========================================
		// apb slave: one wait state, side effects at the completing edge
		acc_ph = psel && penable && !s.pready;
		wr_done = psel && penable && s.pready && pwrite;
		rd_done = psel && penable && s.pready && !pwrite;
		n.pready = acc_ph;
		if (acc_ph) begin
			n.pslverr = 1'b0;
			n.rpop = (paddr == REG_RXDATA) && rx_ne;
			case (paddr)
				REG_CTRL: rdv[CTRL_RXEN] = s.rx_en;
				REG_STATUS: begin
					rdv[ST_TXIRQ] = s.tx_irq;
					rdv[ST_TIMEOUT] = s.timeout;
					rdv[ST_RXNE] = rx_ne;
					rdv[ST_BUSY] = (s.st != TX_IDLE);
				end
				REG_RXDATA: rdv[15:0] = rx_ne ? rxq[s.rd_ptr[10:0]] : QEMPTY_WORD;
				REG_STATION: rdv[7:0] = s.sw2;
				REG_TXDATA, REG_CLRTX, REG_FILTER: rdv = '0;
				default: n.pslverr = 1'b1;
			endcase
			n.prdata = rdv;
		end
		if (wr_done && paddr == REG_CTRL) begin
			n.rx_en = pwdata[CTRL_RXEN];
		end
		if (wr_done && paddr == REG_FILTER) begin
			n.filt[pwdata[7:0]] = pwdata[FLT_VAL];
		end
		// pop on the answer given, so a packet committed mid-read is not skipped
		if (rd_done && paddr == REG_RXDATA && s.rpop) begin
			n.rd_ptr = s.rd_ptr + 12'h001;
		end
		if (wr_done && paddr == REG_CLRTX) begin
			n.tx_irq = 1'b0;
		end

		// ========================================
		// transmitter
		timed_out = (s.to >= 23'(TIMEOUT_LIM - 1));
		if (s.st != TX_IDLE && s.st != TX_LOAD) begin
			n.to = s.to + 23'h000001;
		end
		case (s.seg)
			SEG_START: cur_bit = 1'b1;
			SEG_DATA: cur_bit = txm[s.tx_ptr][4'hF - s.tx_bit];
			default: cur_bit = tcrc[4'hF - s.tx_bit];
		endcase
		case (s.st)
			TX_IDLE: begin
				if (wr_done && paddr == REG_TXDATA && pwdata[10:0] != 11'h000 &&
					pwdata[10:0] <= 11'(TXQ_DEPTH)) begin
					n.st = TX_LOAD;
					n.tx_cnt = pwdata[10:0];
					n.tx_ptr = '0;
					n.timeout = 1'b0;
				end
			end
			TX_LOAD: begin
				if (wr_done && paddr == REG_TXDATA) begin
					txm_we = 1'b1;
					n.tx_ptr = s.tx_ptr + 10'h001;
					if ({1'b0, s.tx_ptr} == s.tx_cnt - 11'h001) begin
						n.st = TX_DEFER;
						n.to = '0;
						n.retries = '0;
					end
				end
			end
			TX_DEFER: begin
				if (timed_out) begin
					n.st = TX_DONE;
					n.timeout = 1'b1;
				end else if (!s.car2 && hb) begin
					n.st = TX_SEND;
					n.seg = SEG_START;
					n.tx_ptr = '0;
					n.tx_bit = '0;
					n.tx_en = 1'b1;
					n.tx_out = 1'b1;
					n.half = 1'b1;
					tcrc_clr = 1'b1;
				end
			end
			TX_SEND: begin
				if (s.col2) begin
					n.st = TX_JAM;
					n.jam = '0;
					n.half = 1'b0;
				end else if (hb) begin
					n.half = !s.half;
					if (!s.half && s.seg == SEG_START) begin
						// start segment on a first half: the last crc half has gone out
						n.st = TX_DONE;
						n.tx_en = 1'b0;
						n.tx_out = 1'b0;
					end else if (!s.half) begin
						n.tx_out = cur_bit;
						tcrc_en = (s.seg == SEG_DATA);
						tcrc_din = cur_bit;
					end else begin
						n.tx_out = !cur_bit;
						n.tx_bit = s.tx_bit + 4'h1;
						if (s.seg == SEG_START) begin
							n.seg = SEG_DATA;
							n.tx_bit = '0;
						end else if (s.seg == SEG_DATA && s.tx_bit == 4'hF) begin
							n.tx_ptr = s.tx_ptr + 10'h001;
							if ({1'b0, s.tx_ptr} == s.tx_cnt - 11'h001) begin
								n.seg = SEG_CRC;
							end
						end else if (s.seg == SEG_CRC && s.tx_bit == 4'hF) begin
							n.seg = SEG_START;
						end
					end
				end
			end
			TX_JAM: begin
				if (hb) begin
					n.half = !s.half;
					n.tx_out = !s.half;
					if (s.half) begin
						n.jam = s.jam + 5'h01;
						if (s.jam == 5'(JAM_BITS - 1)) begin
							rnew = (s.retries < 4'(MAX_BACKOFF)) ? s.retries + 4'h1 : s.retries;
							slots = 4'(32'(s.lfsr) % (32'(rnew) + 32'd1));
							n.retries = rnew;
							n.bo = 14'(32'(slots) * SLOT_CYC);
							n.st = TX_BACKOFF;
							n.tx_en = 1'b0;
							n.tx_out = 1'b0;
						end
					end
				end
			end
			TX_BACKOFF: begin
				if (timed_out) begin
					n.st = TX_DONE;
					n.timeout = 1'b1;
				end else if (s.bo == 14'h0000) begin
					n.st = TX_DEFER;
				end else begin
					n.bo = s.bo - 14'h0001;
				end
			end
			TX_DONE: begin
				n.tx_irq = 1'b1;
				n.st = TX_IDLE;
			end
			default: n.st = TX_IDLE;
		endcase

		// ========================================
		// receiver: edge-timed pll; an edge late in the bit is the mid-bit one
		e = s.rx2 ^ s.rxp;
		rx_end = s.ract && !e && (s.rcnt >= 4'(RX_END_IDLE));
		if (!s.ract) begin
			if (e && s.rx_en) begin
				n.ract = 1'b1;
				n.rcnt = 4'(HALF_CYC);
				n.nbits = '0;
				n.rbc = '0;
				n.havep = 1'b0;
				n.first = 1'b1;
				n.acc = 1'b0;
				n.rcoll = 1'b0;
				n.rovf = 1'b0;
				n.rphs = 1'b0;
				n.wc = '0;
				rcrc_clr = 1'b1;
			end
		end else begin
			n.rcnt = (s.rcnt == 4'hF) ? s.rcnt : s.rcnt + 4'h1;
			if (s.col2) begin
				n.rcoll = 1'b1;
			end
			if (e && s.rcnt >= 4'(RX_MID_MIN)) begin
				bitv = s.rxp;
				n.rcnt = '0;
				n.nbits = s.nbits + 16'h0001;
				if (s.nbits != 16'h0000) begin
					rcrc_en = 1'b1;
					rcrc_din = bitv;
					n.rsh = {s.rsh[14:0], bitv};
					n.rbc = s.rbc + 4'h1;
					if (s.rbc == 4'hF) begin
						w = {s.rsh[14:0], bitv};
						n.pend = w;
						n.havep = 1'b1;
						if (s.first) begin
							n.first = 1'b0;
							n.acc = (s.filt[w[15:8]] || w[15:8] == 8'h00) &&
								((s.wr_ptr - s.rd_ptr) < 12'(RXQ_DEPTH));
							n.base = s.wr_ptr;
							n.wp = s.wr_ptr + 12'h001;
						end else if (s.havep && s.acc) begin
							if ((s.wp - s.rd_ptr) < 12'(RXQ_DEPTH)) begin
								rxq_we = 1'b1;
								rxq_wa = s.wp[10:0];
								rxq_wd = s.pend;
								n.wp = s.wp + 12'h001;
								n.wc = s.wc + 11'h001;
							end else begin
								n.rovf = 1'b1;
							end
						end
					end
				end
			end else if (e && s.rcnt <= 4'(RX_PHASE_MAX)) begin
				n.rphs = 1'b1;
			end
			if (rx_end) begin
				n.ract = 1'b0;
				if (s.acc && s.nbits >= 16'(FRAG_BITS)) begin
					rxq_we = 1'b1;
					rxq_wa = s.base[10:0];
					rxq_wd = {5'h00, s.wc};
					rxq_wd[CW_PHS] = s.rphs || (s.rbc != 4'h0);
					rxq_wd[CW_CRC] = (rcrc != 16'h0000);
					rxq_wd[CW_COLL] = s.rcoll;
					rxq_wd[CW_OVF] = s.rovf;
					n.wr_ptr = s.wp;
				end
			end
		end
		n.rx_irq = (n.wr_ptr != n.rd_ptr);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.lfsr <= LFSR_SEED;
		end else begin
			s <= n;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign tx_out = s.tx_out;
	assign tx_en = s.tx_en;
	assign tx_irq = s.tx_irq;
	assign rx_irq = s.rx_irq;

	// ========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_rx_irq_set: assert property (
		rx_ne |-> s.rx_irq) else $error("receive interrupt low with packet queued");
	a_rx_irq_clear: assert property (
		!rx_ne |-> !s.rx_irq) else $error("receive interrupt high with queue empty");
	a_defer_carrier: assert property (
		(s.st == TX_DEFER && s.car2) |=> s.st != TX_SEND) else $error("sent over carrier");
	a_coll_jam: assert property (
		(s.st == TX_SEND && s.col2) |=> (s.st == TX_JAM && s.tx_en)) else $error("no jam");
	a_done_irq: assert property (
		(s.st == TX_DONE) |=> s.tx_irq) else $error("transmit interrupt not raised");
	a_timeout_abort: assert property (
		(s.st == TX_BACKOFF && timed_out) |=> (s.st == TX_DONE && s.timeout))
		else $error("timeout did not abort");
	a_ok_no_flag: assert property (
		($past(s.st) == TX_SEND && s.st == TX_DONE) |-> !s.timeout)
		else $error("timeout flag on a sent packet");
	a_manch_half: assert property (
		(s.st == TX_SEND && hb && s.half && !s.col2) |=> s.tx_out != $past(s.tx_out))
		else $error("no mid-bit transition");
	a_backoff_max: assert property (
		(s.st == TX_BACKOFF) |-> s.bo <= 14'(MAX_BACKOFF * SLOT_CYC))
		else $error("backoff beyond eight slots");
	a_frag_drop: assert property (
		(rx_end && s.nbits < 16'(FRAG_BITS)) |=> $stable(s.wr_ptr))
		else $error("fragment entered the queue");
	a_filter_drop: assert property (
		(rx_end && !s.acc) |=> $stable(s.wr_ptr)) else $error("rejected packet queued");
	a_commit_irq: assert property (
		(rx_end && s.acc && s.nbits >= 16'(FRAG_BITS)) |=> s.rx_irq)
		else $error("committed packet raised no receive interrupt");
endmodule : em3_mac

// File: dv/em3_xcvr.sv
// ========
// transceiver model: loops our own stream back, fakes carrier, collision and short bursts
module em3_xcvr (
	input wire logic clk,
	input wire logic tx_out,
	input wire logic tx_en,
	input wire logic loop,
	input wire logic carr_req,
	input wire logic coll_req,
	output logic rx_in,
	output logic carrier_in,
	output logic coll_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic bits[$];
	int ph = 0;
	int frames = 0;
	int flen = 0;
	int mcerr = 0;
	logic ten_d = 1'b0;
	logic fd = 1'b0;
	logic fbusy = 1'b0;
	initial begin
		rx_in = 1'b0;
		carrier_in = 1'b0;
		coll_in = 1'b0;
	end
	// ========
	// line drivers; a quiet line sits at 0, its idle level
	always @(posedge clk) begin
		rx_in <= loop ? (tx_out & tx_en) : fd;
		carrier_in <= carr_req | fbusy;
		coll_in <= coll_req & tx_en;
	end
	// ========
	// decoder: first half carries the bit, second half must be its inverse
	always @(posedge clk) begin
		if (!tx_en && ten_d) begin
			frames++;
			flen = ph;
		end
		if (tx_en) begin
			if (ph % 8 == 2) bits.push_back(tx_out);
			if (ph % 8 == 6 && tx_out !== ~bits[$]) mcerr++;
			ph++;
		end else begin
			ph = 0;
		end
		ten_d = tx_en;
	end
	// burst of ones, too short to be a frame
	task automatic send_frag(input int n);
		fbusy <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			fd <= 1'b1;
			repeat (4) @(posedge clk);
			fd <= 1'b0;
			repeat (3) @(posedge clk);
		end
		@(posedge clk);
		fbusy <= 1'b0;
	endtask : send_frag
endmodule : em3_xcvr

// File: dv/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import em3_pkg::*;
	logic clk, rstn, psel, penable, pwrite, err;
	logic [PADDR_W-1:0] paddr;
	logic [PDATA_W-1:0] pwdata, prdata, rd;
	logic pready, pslverr, tx_out, tx_en, rx_in, carrier_in, coll_in, tx_irq, rx_irq;
	logic [7:0] station_sw, d;
	logic loop, carr_req, coll_req;
	logic [15:0] pw[$];
	int seed = 95385;
	int miscompares = 0;
	int compares = 0;
	int cyc = 0;
	int n, f;
	// short timeout keeps the collision run brief; it still exceeds frame plus jam
	em3_mac #(.TIMEOUT_LIM(20000)) dut (.clk(clk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_out(tx_out), .tx_en(tx_en), .rx_in(rx_in),
		.carrier_in(carrier_in), .coll_in(coll_in), .station_sw(station_sw),
		.tx_irq(tx_irq), .rx_irq(rx_irq));
	em3_xcvr xc (.clk(clk), .tx_out(tx_out), .tx_en(tx_en), .loop(loop), .carr_req(carr_req),
		.coll_req(coll_req), .rx_in(rx_in), .carrier_in(carrier_in), .coll_in(coll_in));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ========
	// checking and closing
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic finish_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			miscompares++;
			finish_test();
		end
	end
	// ========
	// bus master: waits for pready however long; the global limit cuts a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		apb(1'b1, a, dat);
	endtask : wr
	task automatic rdreg(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rdreg
	// ========
	// expectations
	function automatic logic [15:0] crc_words(input int cnt);
		logic [15:0] c;
		logic fb;
		c = CRC_INIT;
		for (int i = 0; i < cnt; i++) begin
			for (int b = 15; b >= 0; b--) begin
				fb = c[15] ^ pw[i][b];
				c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
			end
		end
		return c;
	endfunction : crc_words
	task automatic load(input logic [7:0] dest, input int cnt);
		pw.delete();
		pw.push_back({dest, station_sw});
		for (int i = 1; i < cnt; i++) pw.push_back(16'($random(seed)));
		xc.bits.delete();
		wr(REG_TXDATA, 32'(cnt));
		foreach (pw[i]) wr(REG_TXDATA, {16'h0000, pw[i]});
	endtask : load
	task automatic check_tx(input int cnt);
		logic [15:0] w;
		while (tx_irq !== 1'b1) @(posedge clk);
		repeat (20) @(posedge clk);
		chk("tx_bits", 32'(xc.bits.size()), 32'(16 * cnt + 17));
		chk("start_bit", 32'(xc.bits[0]), 32'h1);
		for (int i = 0; i <= cnt; i++) begin
			for (int b = 0; b < 16; b++) w[15 - b] = xc.bits[1 + 16 * i + b];
			chk("tx_word", 32'(w), 32'(i < cnt ? pw[i] : crc_words(cnt)));
		end
		chk("manchester", 32'(xc.mcerr), 32'h0);
		rdreg(REG_STATUS);
		chk("status_tx", rd & 32'h3, 32'h1);
		wr(REG_CLRTX, 32'h0);
		rdreg(REG_STATUS);
		chk("tx_irq_clr", rd & 32'h1, 32'h0);
		chk("tx_irq_pin", 32'(tx_irq), 32'h0);
	endtask : check_tx
	task automatic check_rx(input logic acc, input int cnt);
		repeat (40) @(posedge clk);
		chk("rx_irq", 32'(rx_irq), 32'(acc));
		if (acc) begin
			rdreg(REG_STATUS);
			chk("rx_ne", rd & 32'h4, 32'h4);
			rdreg(REG_RXDATA);
			chk("rx_ctrl", rd, 32'(cnt));
			foreach (pw[i]) begin
				rdreg(REG_RXDATA);
				chk("rx_word", rd, {16'h0000, pw[i]});
			end
		end
		repeat (4) @(posedge clk);
		chk("rx_irq_empty", 32'(rx_irq), 32'h0);
		rdreg(REG_RXDATA);
		chk("rx_empty", rd, 32'(QEMPTY_WORD));
	endtask : check_rx
	// ========
	// main sequence
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		loop = 1'b1;
		carr_req = 1'b0;
		coll_req = 1'b0;
		station_sw = 8'($random(seed));
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rdreg(REG_STATION);
		chk("station", rd, 32'(station_sw));
		rdreg(8'hFC);
		chk("unmapped", 32'(err), 32'h1);
		rdreg(REG_STATUS);
		chk("status_reset", rd, 32'h0);
		d = {7'($random(seed)), 1'b1};
		wr(REG_CTRL, 32'h1);
		wr(REG_FILTER, {23'h0, 1'b1, d});
		n = 9 + int'($unsigned($random(seed)) % 3);
		load(d, n);
		check_tx(n);
		check_rx(1'b1, n);
		// a zero count must be ignored, so the next load still frames correctly
		wr(REG_TXDATA, 32'h0);
		load(d ^ 8'h02, n);
		check_tx(n);
		check_rx(1'b0, n);
		load(8'h00, n);
		check_tx(n);
		check_rx(1'b1, n);
		carr_req <= 1'b1;
		load(d, n);
		repeat (400) @(posedge clk);
		chk("defer", 32'(xc.bits.size()), 32'h0);
		rdreg(REG_STATUS);
		chk("busy", rd & 32'h8, 32'h8);
		carr_req <= 1'b0;
		check_tx(n);
		check_rx(1'b1, n);
		// every attempt collides until the timeout gives up
		loop <= 1'b0;
		coll_req <= 1'b1;
		f = xc.frames;
		load(d, 9);
		while (tx_irq !== 1'b1) @(posedge clk);
		coll_req <= 1'b0;
		chk("retries", 32'(xc.frames - f > 1), 32'h1);
		chk("jam_len", 32'(xc.flen >= JAM_BITS * 8 && xc.flen < 8 * 161), 32'h1);
		rdreg(REG_STATUS);
		chk("timeout", rd & 32'h3, 32'h3);
		wr(REG_CLRTX, 32'h0);
		xc.send_frag(10);
		check_rx(1'b0, 0);
		finish_test();
	end
endmodule : tb
